// file: src/line_out_pkg.sv
// Package with the line output control register map, layouts and timing.
package line_out_pkg;

  // ==========================================================================
  // Register map (printed offsets are word indices, byte address is 4x).
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ENABLES_INDEX = 12'h05E;
  localparam logic [ADDR_W-1:0] STATUS_INDEX = 12'h05F;
  localparam logic [15:0] ENABLES_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ==========================================================================
  // Field positions inside the stage enable register.
  localparam int LEFT_SHORT_BIT = 7;
  localparam int LEFT_OUTPUT_BIT = 6;
  localparam int LEFT_MIDDLE_BIT = 5;
  localparam int LEFT_INPUT_BIT = 4;
  localparam int RIGHT_SHORT_BIT = 3;
  localparam int RIGHT_OUTPUT_BIT = 2;
  localparam int RIGHT_MIDDLE_BIT = 1;
  localparam int RIGHT_INPUT_BIT = 0;

  // ==========================================================================
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Settle time between input stage and intermediate stage.
  localparam int SETTLE_TIME_NS = 20000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETTLE_W = 12;
  localparam int SETTLE_CYCLES_INT =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [SETTLE_W-1:0] SETTLE_CYCLES =
    SETTLE_W'(SETTLE_CYCLES_INT);

  // ==========================================================================
  // Carriers; bit order matches the register layout.
  typedef struct packed {
    logic short_release;
    logic output_on;
    logic middle_on;
    logic input_on;
  } line_chan_s;

  typedef struct packed {
    line_chan_s left;
    line_chan_s right;
  } line_ctrl_s;

  typedef struct packed {
    logic settled;
    logic early_middle;
    logic early_output;
    logic early_release;
  } order_flags_s;

endpackage

// file: src/line_order_watch.sv
// Per-channel watcher of the line output power-up ordering.
module line_order_watch
(
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Stored stage bits and write-one-to-clear mask.
  input wire line_out_pkg::line_chan_s chan,
  input wire line_out_pkg::order_flags_s clr,
  // Observed ordering state.
  output line_out_pkg::order_flags_s flags_ff
);
  import line_out_pkg::*;

  logic [SETTLE_W-1:0] count_ff;
  logic [SETTLE_W-1:0] nxt_count;
  line_chan_s prev_ff;
  line_chan_s nxt_prev;
  order_flags_s nxt_flags;

  // ==========================================================================
  // Settle counter and sticky flags; a new event wins over a clear.
  always_comb
  begin
    nxt_prev = chan;
    nxt_count = count_ff;
    if (!chan.input_on)
      nxt_count = '0;
    else if (count_ff != SETTLE_CYCLES)
      nxt_count = count_ff + 1'b1;
    nxt_flags = flags_ff & ~clr;
    nxt_flags.settled = (nxt_count == SETTLE_CYCLES);
    // Middle stage raised before the input stage has settled.
    if (chan.middle_on && !prev_ff.middle_on && !flags_ff.settled)
      nxt_flags.early_middle = 1'b1;
    // Output stage raised without the middle stage on.
    if (chan.output_on && !prev_ff.output_on && !chan.middle_on)
      nxt_flags.early_output = 1'b1;
    // Short released before the output stage is on.
    if (chan.short_release && !prev_ff.short_release && !chan.output_on)
      nxt_flags.early_release = 1'b1;
  end

  // Registers only; ce freezes everything except the synchronous reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_ff <= '0;
      prev_ff <= '0;
      flags_ff <= '0;
    end
    else if (ce)
    begin
      count_ff <= nxt_count;
      prev_ff <= nxt_prev;
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================================================
  // Checks.
  early_middle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && chan.middle_on && !prev_ff.middle_on && !flags_ff.settled
    |=> flags_ff.early_middle)
    else $error("early middle stage not flagged");

  settle_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff.settled) |-> count_ff == SETTLE_CYCLES &&
      $past(chan.input_on))
    else $error("settle reported at wrong count");

endmodule // line_order_watch

// file: src/line_output_enable_control.sv
// Line output stage enable register bank with an AXI4-Lite slave.
//
// Local design decision: register access over AXI4-Lite.

module line_output_enable_control
(
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write address channel.
  input wire logic awvalid,
  output logic awready,
  input wire logic [line_out_pkg::ADDR_W-1:0] awaddr,
  // Write data channel.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel.
  input wire logic arvalid,
  output logic arready,
  input wire logic [line_out_pkg::ADDR_W-1:0] araddr,
  // Read data channel.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Stage controls toward the analogue line outputs.
  output line_out_pkg::line_ctrl_s line_ctrl_ff
);
  import line_out_pkg::*;

  // ==========================================================================
  // Address decode shared by the write and read paths.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] index);
    addr_hit = (addr[ADDR_W-1:2] == index[ADDR_W-3:0]);
  endfunction

  // Write path state.
  logic aw_held_ff;
  logic nxt_aw_held;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic w_held_ff;
  logic nxt_w_held;
  logic [31:0] w_data_ff;
  logic [31:0] nxt_w_data;
  logic [3:0] w_strb_ff;
  logic [3:0] nxt_w_strb;
  logic awready_ff;
  logic nxt_awready;
  logic wready_ff;
  logic nxt_wready;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic do_write;
  logic wr_enables;
  logic wr_status;

  // Read path state.
  logic arready_ff;
  logic nxt_arready;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  // Register contents and ordering status.
  line_ctrl_s nxt_line_ctrl;
  order_flags_s left_flags;
  order_flags_s right_flags;
  order_flags_s left_clr;
  order_flags_s right_clr;

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // A write commits once both halves are held and no response is pending.
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_enables = do_write && addr_hit(aw_addr_ff, ENABLES_INDEX);
  assign wr_status = do_write && addr_hit(aw_addr_ff, STATUS_INDEX);

  // ==========================================================================
  // Write channels: address and data are taken in either order.
  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held = w_held_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (awvalid && awready_ff)
    begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = awaddr;
    end
    if (wvalid && wready_ff)
    begin
      nxt_w_held = 1'b1;
      nxt_w_data = wdata;
      nxt_w_strb = wstrb;
    end
    if (do_write)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      if (wr_enables || wr_status)
        nxt_bresp = RESP_OKAY;
      else
        nxt_bresp = RESP_SLVERR;
    end
    else if (bvalid_ff && bready)
      nxt_bvalid = 1'b0;
    // Ready is registered, so it is computed from the next held state.
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready = !nxt_w_held && !nxt_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (ce)
    begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff <= nxt_w_held;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // ==========================================================================
  // Stage enable register; bits 15:8 are reserved, so only lane 0 matters.
  always_comb
  begin
    nxt_line_ctrl = line_ctrl_ff;
    if (wr_enables && w_strb_ff[0])
      nxt_line_ctrl = line_ctrl_s'(w_data_ff[7:0]);
  end

  // The ports are these flip-flops, so a write shows one edge later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_ctrl_ff <= line_ctrl_s'(ENABLES_RESET[7:0]);
    else if (ce)
      line_ctrl_ff <= nxt_line_ctrl;
  end

  // Status flags are write-one-to-clear; the settled bits ignore writes.
  always_comb
  begin
    left_clr = '0;
    right_clr = '0;
    if (wr_status && w_strb_ff[0])
    begin
      left_clr = order_flags_s'(w_data_ff[7:4]);
      right_clr = order_flags_s'(w_data_ff[3:0]);
    end
  end

  // One watcher per channel tracks settle time and ordering slips.
  line_order_watch u_left_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .chan(line_ctrl_ff.left),
    .clr(left_clr),
    .flags_ff(left_flags)
  );

  line_order_watch u_right_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .chan(line_ctrl_ff.right),
    .clr(right_clr),
    .flags_ff(right_flags)
  );

  // ==========================================================================
  // Read channel: one outstanding read, answered the edge after it is taken.
  always_comb
  begin
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arvalid && arready_ff)
    begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      if (addr_hit(araddr, ENABLES_INDEX))
        nxt_rdata = {24'h000000, line_ctrl_ff};
      else if (addr_hit(araddr, STATUS_INDEX))
        nxt_rdata = {24'h000000, left_flags, right_flags};
      else
      begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = RESP_SLVERR;
      end
    end
    else if (rvalid_ff && rready)
    begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
    else if (!rvalid_ff)
      nxt_arready = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (ce)
    begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ==========================================================================
  // Checks: a committed lane-0 write lands in the named bit one edge later.
  property wr_bit(int b);
    @(posedge aclk) disable iff (!aresetn)
    ce && wr_enables && w_strb_ff[0]
    |=> line_ctrl_ff[b] == $past(w_data_ff[b]);
  endproperty

  left_short_a: assert property (wr_bit(LEFT_SHORT_BIT))
    else $error("left short release not stored");
  left_output_a: assert property (wr_bit(LEFT_OUTPUT_BIT))
    else $error("left output stage bit not stored");
  left_middle_a: assert property (wr_bit(LEFT_MIDDLE_BIT))
    else $error("left middle stage bit not stored");
  left_input_a: assert property (wr_bit(LEFT_INPUT_BIT))
    else $error("left input stage bit not stored");
  right_short_a: assert property (wr_bit(RIGHT_SHORT_BIT))
    else $error("right short release not stored");
  right_output_a: assert property (wr_bit(RIGHT_OUTPUT_BIT))
    else $error("right output stage bit not stored");
  right_middle_a: assert property (wr_bit(RIGHT_MIDDLE_BIT))
    else $error("right middle stage bit not stored");
  right_input_a: assert property (wr_bit(RIGHT_INPUT_BIT))
    else $error("right input stage bit not stored");

  // Controls move only because of a register write or reset.
  ctrl_only_written_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !$stable(line_ctrl_ff) && !$past(!aresetn)
    |-> $past(wr_enables && ce))
    else $error("control changed without a write");

  // Reset leaves every stage off and both outputs shorted.
  ctrl_reset_a: assert property (@(posedge aclk)
    !aresetn |=> line_ctrl_ff == '0)
    else $error("controls not zero after reset");

  // A read of the enable register returns the live controls.
  read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && arvalid && arready_ff && addr_hit(araddr, ENABLES_INDEX)
    |=> rvalid_ff && rdata_ff == {24'h000000, $past(line_ctrl_ff)})
    else $error("enable read back wrong");

  // The write response follows the commit within one edge.
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && do_write |=> bvalid_ff ##0 (bresp_ff == RESP_OKAY) ==
      $past(wr_enables || wr_status))
    else $error("write response wrong");

  // Main scenarios.
  left_powered_c: cover property (@(posedge aclk) disable iff (!aresetn)
    line_ctrl_ff.left == 4'hF);
  right_powered_c: cover property (@(posedge aclk) disable iff (!aresetn)
    line_ctrl_ff.right == 4'hF);
  bad_addr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff && bresp_ff == RESP_SLVERR);

endmodule // line_output_enable_control

// file: bench/line_output_enable_control_tb.sv
// Self-checking testbench for the line output stage enable register bank.
module line_output_enable_control_tb import line_out_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Addresses and expectations
  localparam logic [ADDR_W-1:0] EN_ADDR = {ENABLES_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ST_ADDR = {STATUS_INDEX[ADDR_W-3:0], 2'b00};
  // Nothing is decoded here, so both directions must answer with an error.
  localparam logic [ADDR_W-1:0] BAD_ADDR = 12'h200;
  localparam logic [7:0] EARLY_SET [3] = '{8'h22, 8'h44, 8'h88};
  localparam logic [7:0] EARLY_FLAG [3] = '{8'h44, 8'h22, 8'h11};

  // ==========================================================================
  // Stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  line_ctrl_s line_ctrl_ff;
  int fails = 0;
  int n_tests = 0;

  // Free-running 200 MHz clock.
  always #2.5 aclk = ~aclk;

  line_output_enable_control i_dut
  (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .line_ctrl_ff(line_ctrl_ff)
  );

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks
  // Address and data go out together; each is dropped at its own handshake.
  task automatic axi_write(input logic [ADDR_W-1:0] addr,
    input logic [31:0] data, input logic [3:0] strb, input logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= addr;
    wvalid <= 1'b1;
    wdata <= data;
    wstrb <= strb;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // The response does not stand yet at the last address or data edge.
    while (bvalid !== 1'b1)
      @(posedge aclk);
    check({30'h0, bresp}, {30'h0, resp}, "write response");
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] addr,
    input logic [31:0] exp, input logic [1:0] resp);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= addr;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge aclk);
    check(rdata, exp, "read data");
    check({30'h0, rresp}, {30'h0, resp}, "read response");
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Writes the enables, then checks both the outputs and the read-back.
  task automatic put_en(input logic [31:0] data, input logic [7:0] exp);
    axi_write(EN_ADDR, data, 4'hF, RESP_OKAY);
    check({24'h0, line_ctrl_ff}, {24'h0, exp}, "stage controls");
    axi_read(EN_ADDR, {24'h0, exp}, RESP_OKAY);
  endtask

  // ==========================================================================
  // Watchdog, sized well above the two settle waits of the run.
  initial
  begin
    #(20000 * CLK_PERIOD_NS);
    fails++;
    close_out();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({24'h0, line_ctrl_ff}, 32'h0,
      "reset controls");
    axi_read(EN_ADDR, 32'h0, RESP_OKAY);
    // Each bit alone proves position and that no neighbour moves with it.
    for (int i = 0; i < 8; i++)
      put_en(32'h1 << i, 8'h01 << i);
    put_en(32'hFFFF_FFFF, 8'hFF);
    // A write with the low lane masked must leave the stages alone.
    axi_write(EN_ADDR, 32'h0, 4'hE, RESP_OKAY);
    check({24'h0, line_ctrl_ff}, 32'hFF, "masked write");
    axi_write(BAD_ADDR, 32'h0, 4'hF, RESP_SLVERR);
    axi_read(BAD_ADDR, 32'h0, RESP_SLVERR);
    check({24'h0, line_ctrl_ff}, 32'hFF, "unmapped write");
    // Full power-up of both channels in the intended order.
    put_en(32'h00, 8'h00);
    // The single-bit writes above left slips flagged; clear them first.
    axi_write(ST_ADDR, 32'hFF, 4'hF, RESP_OKAY);
    axi_read(ST_ADDR, 32'h00, RESP_OKAY);
    put_en(32'h11, 8'h11);
    repeat (SETTLE_CYCLES_INT + 8) @(posedge aclk);
    put_en(32'h33, 8'h33);
    put_en(32'h77, 8'h77);
    put_en(32'hFF, 8'hFF);
    axi_read(ST_ADDR, 32'h88, RESP_OKAY);
    // Out-of-order steps are flagged, then cleared by writing ones.
    put_en(32'h00, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      put_en({24'h0, EARLY_SET[k]}, EARLY_SET[k]);
      axi_read(ST_ADDR, {24'h0, EARLY_FLAG[k]},
        RESP_OKAY);
      axi_write(ST_ADDR, {24'h0, EARLY_FLAG[k]}, 4'hF, RESP_OKAY);
      axi_read(ST_ADDR, 32'h0, RESP_OKAY);
      put_en(32'h00, 8'h00);
    end
    // With ce low the settle counter is frozen, so a middle stage raised
    // after a long stall still counts as early.
    put_en(32'h11, 8'h11);
    ce <= 1'b0;
    repeat (SETTLE_CYCLES_INT + 8) @(posedge aclk);
    ce <= 1'b1;
    check({24'h0, line_ctrl_ff}, 32'h11, "frozen controls");
    put_en(32'h33, 8'h33);
    axi_read(ST_ADDR, 32'h44, RESP_OKAY);
    // A second reset in mid-run returns every stage to off.
    put_en(32'hA5, 8'hA5);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({24'h0, line_ctrl_ff}, 32'h0,
      "second reset");
    axi_read(EN_ADDR, 32'h0, RESP_OKAY);
    close_out();
  end

endmodule // line_output_enable_control_tb
